// file: logic/mbs_server.v
/*
 * Request server: queue read, encapsulated transport dispatch and device
 * identification, plus the response FIFO (mbs_fifo) that buffers answer bytes.
 * Assumes request bytes arrive framed with a last flag from the transport
 * below, and a register port that returns data one cycle after the read
 * strobe. One clock; all inputs but the async active-low reset synchronous to it.
 */
`timescale 1ns/1ns
`include "mbs_consts.vh"

module mbs_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             in_ready_o,
  output wire             out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr_q;
  reg [AW-1:0]    rptr_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem[rptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage has no reset, it is only read behind a valid count
  always @(posedge mclk_i)
  begin
    if (push)
      mem[wptr_q] <= in_data_i;
  end

  // Pointers wrap at depth, count tracks push minus pop
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      cnt_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wptr_q <= (wptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_q + 1'b1;
      if (pop)
        rptr_q <= (rptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // mbs_fifo

module mbs_server #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        req_valid_i,
  input  wire [7:0]  req_data_i,
  input  wire        req_last_i,
  output wire        req_ready_o,
  output wire        rsp_valid_o,
  output wire [7:0]  rsp_data_o,
  output wire        rsp_last_o,
  input  wire        rsp_ready_i,
  output reg  [15:0] reg_addr_o,
  output reg         reg_rd_o,
  input  wire [15:0] reg_data_i,
  output wire        busy_o
);
  localparam [2:0] S_RX    = 3'd0;
  localparam [2:0] S_DISP  = 3'd1;
  localparam [2:0] S_RWAIT = 3'd2;
  localparam [2:0] S_RCAP  = 3'd3;
  localparam [2:0] S_EMIT  = 3'd4;
  localparam [2:0] S_QRD   = 3'd5;

  localparam [1:0] M_EXC  = 2'd0;
  localparam [1:0] M_ID   = 2'd1;
  localparam [1:0] M_QHDR = 2'd2;
  localparam [1:0] M_QDAT = 2'd3;

  reg [2:0]  state_q;
  reg [1:0]  mode_q;
  reg [7:0]  rq0_q;
  reg [7:0]  rq1_q;
  reg [7:0]  rq2_q;
  reg [7:0]  rq3_q;
  reg [7:0]  rlen_q;
  reg [7:0]  idx_q;
  reg [7:0]  len_q;
  reg [7:0]  exc_fc_q;
  reg [7:0]  exc_code_q;
  reg [15:0] qcnt_q;
  reg [15:0] qi_q;
  reg [15:0] data_q;
  reg        cnt_phase_q;
  reg [7:0]  id_start_q;
  reg [7:0]  id_nobj_q;
  reg [7:0]  cur_byte;
  reg        cur_last;
  wire       push_ready;
  wire       push_valid;
  wire [7:0] id_sel;

  // Identification objects as id, length, ASCII text; strings are arbitrary
  function [7:0] id_rom;
    input [7:0] i;
    begin
      case (i)
        8'h00: id_rom = 8'h00;
        8'h01: id_rom = 8'h04;
        8'h02: id_rom = 8'h56;
        8'h03: id_rom = 8'h4E;
        8'h04: id_rom = 8'h44;
        8'h05: id_rom = 8'h52;
        8'h06: id_rom = 8'h01;
        8'h07: id_rom = 8'h04;
        8'h08: id_rom = 8'h50;
        8'h09: id_rom = 8'h30;
        8'h0A: id_rom = 8'h30;
        8'h0B: id_rom = 8'h31;
        8'h0C: id_rom = 8'h02;
        8'h0D: id_rom = 8'h03;
        8'h0E: id_rom = 8'h31;
        8'h0F: id_rom = 8'h2E;
        8'h10: id_rom = 8'h30;
        default: id_rom = 8'h00;
      endcase
    end
  endfunction

  // Start of an object in the table, end of table past the last one
  function [7:0] obj_off;
    input [7:0] id;
    begin
      case (id)
        8'h00: obj_off = 8'h00;
        8'h01: obj_off = `MBS_ID_OFF1;
        8'h02: obj_off = `MBS_ID_OFF2;
        default: obj_off = `MBS_ID_ROM_LEN;
      endcase
    end
  endfunction

  // High byte goes first on every two-byte field
  function [7:0] hi_lo;
    input [15:0] v;
    input        lo;
    begin
      hi_lo = lo ? v[7:0] : v[15:8];
    end
  endfunction

  assign req_ready_o = (state_q == S_RX);
  assign push_valid  = (state_q == S_EMIT);
  assign busy_o      = (state_q != S_RX);
  // Unknown ids and the private range fall back to object 0 in stream mode
  assign id_sel      = (rq3_q > `MBS_ID_LAST_OBJ) ? 8'h00 : rq3_q;

  // Response byte selected by mode and position within the PDU
  always @*
  begin
    cur_byte = 8'h00;
    cur_last = 1'b0;
    case (mode_q)
      M_EXC:
      begin
        cur_byte = (idx_q == 8'h00) ? exc_fc_q : exc_code_q;
        cur_last = (idx_q == `MBS_EXC_LEN - 8'h01);
      end
      M_ID:
      begin
        case (idx_q)
          8'h00: cur_byte = `MBS_FC_ENCAP;
          8'h01: cur_byte = rq1_q;
          8'h02: cur_byte = rq2_q;
          8'h03: cur_byte = `MBS_CONFORMITY;
          8'h04: cur_byte = `MBS_MORE_NONE;
          8'h05: cur_byte = 8'h00;
          8'h06: cur_byte = id_nobj_q;
          default: cur_byte = id_rom(id_start_q + idx_q - `MBS_IDHDR_LEN);
        endcase
        cur_last = (idx_q == len_q - 8'h01);
      end
      M_QHDR:
      begin
        case (idx_q)
          8'h00: cur_byte = `MBS_FC_QUEUE;
          8'h01: cur_byte = hi_lo({qcnt_q[14:0], 1'b0} + 16'h0002, 1'b0);
          8'h02: cur_byte = hi_lo({qcnt_q[14:0], 1'b0} + 16'h0002, 1'b1);
          8'h03: cur_byte = hi_lo(qcnt_q, 1'b0);
          default: cur_byte = hi_lo(qcnt_q, 1'b1);
        endcase
        cur_last = (idx_q == `MBS_QHDR_LEN - 8'h01) && (qcnt_q == 16'h0000);
      end
      default:
      begin
        cur_byte = hi_lo(data_q, idx_q[0]);
        cur_last = (idx_q == `MBS_QDAT_LEN - 8'h01) && (qi_q == qcnt_q);
      end
    endcase
  end

  // Request capture, dispatch and response sequencing
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q     <= S_RX;
      mode_q      <= M_EXC;
      rq0_q       <= 8'h00;
      rq1_q       <= 8'h00;
      rq2_q       <= 8'h00;
      rq3_q       <= 8'h00;
      rlen_q      <= 8'h00;
      idx_q       <= 8'h00;
      len_q       <= 8'h00;
      exc_fc_q    <= 8'h00;
      exc_code_q  <= 8'h00;
      qcnt_q      <= 16'h0000;
      qi_q        <= 16'h0000;
      data_q      <= 16'h0000;
      cnt_phase_q <= 1'b0;
      id_start_q  <= 8'h00;
      id_nobj_q   <= 8'h00;
      reg_addr_o  <= 16'h0000;
      reg_rd_o    <= 1'b0;
    end
    else
    begin
      reg_rd_o <= 1'b0;
      case (state_q)
        S_RX:
        begin
          if (req_valid_i)
          begin
            case (rlen_q)
              8'h00: rq0_q <= req_data_i;
              8'h01: rq1_q <= req_data_i;
              8'h02: rq2_q <= req_data_i;
              8'h03: rq3_q <= req_data_i;
              default: ;
            endcase
            // Length saturates so oversized PDUs stay detectable
            if (rlen_q != 8'hFF)
              rlen_q <= rlen_q + 8'h01;
            if (req_last_i)
              state_q <= S_DISP;
          end
        end
        S_DISP:
        begin
          idx_q      <= 8'h00;
          mode_q     <= M_EXC;
          len_q      <= `MBS_EXC_LEN;
          exc_fc_q   <= rq0_q | `MBS_FC_EXC_BIT;
          exc_code_q <= `MBS_EX_VALUE;
          state_q    <= S_EMIT;
          rlen_q     <= 8'h00;
          if (rq0_q == `MBS_FC_QUEUE)
          begin
            if (rlen_q == `MBS_QREQ_LEN)
            begin
              // Queue count lives at the pointer register itself
              reg_addr_o  <= {rq1_q, rq2_q};
              reg_rd_o    <= 1'b1;
              cnt_phase_q <= 1'b1;
              state_q     <= S_RWAIT;
            end
          end
          else if (rq0_q == `MBS_FC_ENCAP)
          begin
            if (rlen_q < `MBS_ENC_MIN_LEN)
              exc_code_q <= `MBS_EX_VALUE;
            else if (rq1_q == `MBS_IF_IDENT)
            begin
              if (rlen_q != `MBS_IDREQ_LEN)
                exc_code_q <= `MBS_EX_VALUE;
              else if (rq2_q < `MBS_AC_BASIC || rq2_q > `MBS_AC_SINGLE)
                exc_code_q <= `MBS_EX_VALUE;
              else if (rq2_q == `MBS_AC_SINGLE)
              begin
                if (rq3_q > `MBS_ID_LAST_OBJ)
                  exc_code_q <= `MBS_EX_ADDR;
                else
                begin
                  mode_q     <= M_ID;
                  id_start_q <= obj_off(rq3_q);
                  id_nobj_q  <= 8'h01;
                  len_q      <= `MBS_IDHDR_LEN + obj_off(rq3_q + 8'h01) - obj_off(rq3_q);
                end
              end
              else
              begin
                // All basic objects fit one response, so no continuation
                mode_q     <= M_ID;
                id_start_q <= obj_off(id_sel);
                id_nobj_q  <= `MBS_ID_NUM_OBJ - id_sel;
                len_q      <= `MBS_IDHDR_LEN + `MBS_ID_ROM_LEN - obj_off(id_sel);
              end
            end
            else if (rq1_q == `MBS_IF_OBJDICT && rlen_q > `MBS_PDU_MAX)
              exc_code_q <= `MBS_EX_VALUE;
            else
              // No object dictionary service behind this server
              exc_code_q <= `MBS_EX_FUNC;
          end
          else
            exc_code_q <= `MBS_EX_FUNC;
        end
        S_RWAIT:
          state_q <= S_RCAP;
        S_RCAP:
        begin
          idx_q   <= 8'h00;
          state_q <= S_EMIT;
          if (cnt_phase_q)
          begin
            cnt_phase_q <= 1'b0;
            qcnt_q      <= reg_data_i;
            qi_q        <= 16'h0000;
            if (reg_data_i > `MBS_QUEUE_MAX)
            begin
              mode_q     <= M_EXC;
              len_q      <= `MBS_EXC_LEN;
              exc_code_q <= `MBS_EX_VALUE;
            end
            else
            begin
              mode_q <= M_QHDR;
              len_q  <= `MBS_QHDR_LEN;
            end
          end
          else
          begin
            data_q <= reg_data_i;
            mode_q <= M_QDAT;
            len_q  <= `MBS_QDAT_LEN;
          end
        end
        S_QRD:
        begin
          // Successive registers after the pointer, read without side effect
          reg_addr_o <= reg_addr_o + 16'h0001;
          reg_rd_o   <= 1'b1;
          qi_q       <= qi_q + 16'h0001;
          state_q    <= S_RWAIT;
        end
        S_EMIT:
        begin
          // Stalls here while the response FIFO is full
          if (push_ready)
          begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == len_q - 8'h01)
            begin
              if (cur_last)
                state_q <= S_RX;
              else
                state_q <= S_QRD;
            end
          end
        end
        default:
          state_q <= S_RX;
      endcase
    end
  end

  // Response bytes queue here so a slow transport back-pressures the server
  mbs_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rsp_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_valid),
    .in_data_i   ({cur_last, cur_byte}),
    .in_ready_o  (push_ready),
    .out_valid_o (rsp_valid_o),
    .out_data_o  ({rsp_last_o, rsp_data_o}),
    .out_ready_i (rsp_ready_i)
  );
endmodule // mbs_server

// file: logic/mbs_consts.vh
/*
 * Constants for the request server: function codes, interface types,
 * access codes, exception codes, field limits and identification data layout.
 * Assumes it is included by bare name from the design file.
 */
`ifndef MBS_CONSTS_VH
`define MBS_CONSTS_VH

// Function codes and exception flag
`define MBS_FC_QUEUE      8'h18
`define MBS_FC_ENCAP      8'h2B
`define MBS_FC_EXC_BIT    8'h80
// Encapsulated interface types
`define MBS_IF_OBJDICT    8'h0D
`define MBS_IF_IDENT      8'h0E
// Identification access codes
`define MBS_AC_BASIC      8'h01
`define MBS_AC_SINGLE     8'h04
// Exception codes
`define MBS_EX_FUNC       8'h01
`define MBS_EX_ADDR       8'h02
`define MBS_EX_VALUE      8'h03
// Continuation flag values
`define MBS_MORE_NONE     8'h00
`define MBS_MORE_YES      8'hFF
// Conformity: basic level, stream and single access
`define MBS_CONFORMITY    8'h81
// Queue limits and field sizes
`define MBS_QUEUE_MAX     16'h001F
`define MBS_QREQ_LEN      8'h03
`define MBS_IDREQ_LEN     8'h04
`define MBS_ENC_MIN_LEN   8'h02
`define MBS_PDU_MAX       8'hFD
`define MBS_QHDR_LEN      8'h05
`define MBS_QDAT_LEN      8'h02
`define MBS_EXC_LEN       8'h02
`define MBS_IDHDR_LEN     8'h07
// Identification object table
`define MBS_ID_LAST_OBJ   8'h02
`define MBS_ID_NUM_OBJ    8'h03
`define MBS_ID_ROM_LEN    8'h11
`define MBS_ID_OFF1       8'h06
`define MBS_ID_OFF2       8'h0C

`endif

// file: verif/mbs_chk.sv
/* Port checker for mbs_server.
   Assumes the bind below; one clock, async active-low reset. */
`timescale 1ns/1ns
module mbs_chk (
  input wire        mclk_i,
  input wire        rst_n_i,
  input wire        req_valid_i,
  input wire [7:0]  req_data_i,
  input wire        req_last_i,
  input wire        req_ready_o,
  input wire        rsp_valid_o,
  input wire [7:0]  rsp_data_o,
  input wire        rsp_last_o,
  input wire        rsp_ready_i,
  input wire [15:0] reg_addr_o,
  input wire        reg_rd_o,
  input wire [15:0] reg_data_i,
  input wire        busy_o
);
  reg [7:0]  fc_q;
  reg [15:0] pt_q;
  reg [15:0] la_q;
  reg [5:0]  rd_q;
  reg        rf_q;
  reg        sf_q;
  reg        ex_q;
  reg        nr_q;
  wire       tk_w;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  assign tk_w = req_valid_i && req_ready_o;

  // Frame tracking; any request byte restarts the read bookkeeping
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fc_q <= 8'h00;
      pt_q <= 16'h0000;
      la_q <= 16'h0000;
      rd_q <= 6'h00;
      rf_q <= 1'b1;
      sf_q <= 1'b1;
      ex_q <= 1'b0;
      nr_q <= 1'b0;
    end
    else
    begin
      rf_q <= tk_w ? req_last_i : rf_q;
      pt_q <= tk_w ? {pt_q[7:0], req_data_i} : pt_q;
      fc_q <= (tk_w && rf_q) ? req_data_i : fc_q;
      rd_q <= tk_w ? 6'h00 : rd_q + {5'h00, reg_rd_o};
      nr_q <= tk_w ? 1'b0 : (nr_q | reg_rd_o);
      la_q <= reg_rd_o ? reg_addr_o : la_q;
      sf_q <= (rsp_valid_o && rsp_ready_i) ? rsp_last_o : sf_q;
      ex_q <= (rsp_valid_o && rsp_ready_i) ? (sf_q & rsp_data_o[7]) : ex_q;
    end
  end

  sequence s_take;
    rsp_valid_o && rsp_ready_i;
  endsequence
  sequence s_rd_gap;
    !reg_rd_o ##1 !reg_rd_o;
  endsequence

  // Register port: one strobe, then wait and capture cycles
  a_rd_pulse: assert property (reg_rd_o |=> s_rd_gap)
    else $error("read strobe repeats too soon");
  a_first_ptr: assert property (reg_rd_o && !nr_q |-> reg_addr_o == pt_q)
    else $error("first read not at pointer");
  a_addr_step: assert property (reg_rd_o && nr_q |-> reg_addr_o == la_q + 16'h0001)
    else $error("read address did not step by one");
  a_rd_limit: assert property (reg_rd_o |-> rd_q < 6'h20)
    else $error("more than 32 reads");
  a_rd_busy: assert property (reg_rd_o |-> busy_o && !req_ready_o)
    else $error("read outside a request");
  // Response stream
  a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=>
    rsp_valid_o && $stable(rsp_data_o) && $stable(rsp_last_o))
    else $error("response byte changed while stalled");
  a_fc_echo: assert property (s_take ##0 sf_q |-> rsp_data_o[6:0] == fc_q[6:0])
    else $error("function byte not echoed");
  a_exc_code: assert property (s_take ##0 ex_q |->
    rsp_last_o && rsp_data_o >= 8'h01 && rsp_data_o <= 8'h04)
    else $error("bad exception code byte");
endmodule // mbs_chk

bind mbs_server mbs_chk chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .req_valid_i(req_valid_i), .req_data_i(req_data_i), .req_last_i(req_last_i),
  .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .rsp_last_o(rsp_last_o), .rsp_ready_i(rsp_ready_i), .reg_addr_o(reg_addr_o),
  .reg_rd_o(reg_rd_o), .reg_data_i(reg_data_i), .busy_o(busy_o));

// file: verif/mbs_reg_model.sv
/* Register bank behind the queue read port.
   Assumes data is wanted one cycle after the strobe; count sits at ptr_i. */
`timescale 1ns/1ns
module mbs_reg_model (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire [15:0] ptr_i,
  input  wire [15:0] cnt_i,
  input  wire [15:0] reg_addr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_data_o
);
  // Read-only bank; outside the answer cycle the bus toggles so stale data
  // cannot pass for valid
  always @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_data_o <= 16'h0000;
    else if (reg_rd_i)
      reg_data_o <= (reg_addr_i == ptr_i) ? cnt_i : reg_addr_i ^ 16'h5A5A;
    else
      reg_data_o <= ~reg_data_o;
  end
endmodule // mbs_reg_model

// file: verif/tb_top.sv
/* Self-checking bench for mbs_server.
   Assumes mbs_reg_model answers reads; the bench drives requests. */
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t got %h want %h", $time, g, e); end end
module tb_top;
  logic        mclk_i;
  logic        rst_n_i;
  logic        req_valid_i;
  logic [7:0]  req_data_i;
  logic        req_last_i;
  logic        rsp_ready_i;
  logic [15:0] ptr;
  logic [15:0] cnt;
  wire         req_ready_o;
  wire         rsp_valid_o;
  wire  [7:0]  rsp_data_o;
  wire         rsp_last_o;
  wire  [15:0] reg_addr_o;
  wire         reg_rd_o;
  wire  [15:0] reg_data_i;
  wire         busy_o;
  int          num_errors = 0;
  int          checks = 0;

  mbs_server dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_data_i(req_data_i), .req_last_i(req_last_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_last_o(rsp_last_o),
    .rsp_ready_i(rsp_ready_i), .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o),
    .reg_data_i(reg_data_i), .busy_o(busy_o));
  mbs_reg_model reg_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ptr_i(ptr), .cnt_i(cnt),
    .reg_addr_i(reg_addr_o), .reg_rd_i(reg_rd_o), .reg_data_o(reg_data_i));

  // 10 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Offer one request, then drain the answer with periodic stalls
  task automatic run(input logic [7:0] rq[$], input logic [7:0] ex[$], input int stall);
    logic [7:0] got[$];
    int n;
    foreach (rq[i])
    begin
      @(negedge mclk_i);
      req_valid_i = 1'b1;
      req_data_i = rq[i];
      req_last_i = (i == rq.size() - 1);
      n = 0;
      while (req_ready_o !== 1'b1)
      begin
        @(negedge mclk_i);
        n++;
        if (n > 50)
        begin
          num_errors++;
          $display("mismatch at %0t request byte never taken", $time);
          tally_and_finish;
        end
      end
    end
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    req_last_i = 1'b0;
    for (n = 0; n < 3000; n++)
    begin
      rsp_ready_i = (n >= stall) && (n % 3 != 1);
      if (n == stall - 1)
        `CHK(busy_o, 1'b1)
      if (rsp_valid_o === 1'b1 && rsp_ready_i)
      begin
        got.push_back(rsp_data_o);
        if (rsp_last_o === 1'b1)
          break;
      end
      @(negedge mclk_i);
    end
    if (n >= 3000)
    begin
      num_errors++;
      $display("mismatch at %0t response never completed", $time);
      tally_and_finish;
    end
    @(negedge mclk_i);
    rsp_ready_i = 1'b0;
    `CHK(got.size(), ex.size())
    foreach (ex[i])
      if (i < got.size())
        `CHK(got[i], ex[i])
    repeat (2) @(negedge mclk_i);
  endtask

  // Queue read with expected answer built from the bank's contents
  task automatic q(input logic [15:0] p, input logic [15:0] c, input int stall);
    logic [7:0]  ex[$];
    logic [15:0] v;
    ptr = p;
    cnt = c;
    ex = {8'h98, 8'h03};
    if (c <= 16'h001F)
    begin
      v = 16'h0002 + 16'h0002 * c;
      ex = {8'h18, v[15:8], v[7:0], c[15:8], c[7:0]};
      for (int k = 1; k <= c; k++)
      begin
        v = (p + k[15:0]) ^ 16'h5A5A;
        ex.push_back(v[15:8]);
        ex.push_back(v[7:0]);
      end
    end
    run({8'h18, p[15:8], p[7:0]}, ex, stall);
  endtask

  // Append one identification object: id, length, text
  function automatic void add_obj(ref logic [7:0] e[$], input int id);
    string s;
    s = (id == 0) ? "VNDR" : (id == 1) ? "P001" : "1.0";
    e.push_back(8'(id));
    e.push_back(8'(s.len()));
    // Index loop, since not every simulator walks a string with foreach
    for (int i = 0; i < s.len(); i++)
      e.push_back(s[i]);
  endfunction

  task automatic sc_queue;
    q(16'h04DE, 16'h0002, 0);
    q(16'h04DE, 16'h0002, 0);
    q(16'h0200, 16'h0000, 0);
    $display("queue read test done");
  endtask

  task automatic sc_queue_limit;
    q(16'hFFC0, 16'h001F, 60);
    q(16'h0100, 16'h0020, 0);
    run({8'h18, 8'h04}, {8'h98, 8'h03}, 0);
    $display("queue limit test done");
  endtask

  task automatic sc_ident;
    logic [7:0] e[$];
    for (int id = 0; id < 3; id++)
    begin
      e = {8'h2B, 8'h0E, 8'h04, 8'h81, 8'h00, 8'h00, 8'h01};
      add_obj(e, id);
      run({8'h2B, 8'h0E, 8'h04, 8'(id)}, e, 0);
    end
    for (int ac = 1; ac < 4; ac++)
    begin
      e = {8'h2B, 8'h0E, 8'(ac), 8'h81, 8'h00, 8'h00, 8'h03};
      for (int k = 0; k < 3; k++)
        add_obj(e, k);
      run({8'h2B, 8'h0E, 8'(ac), (ac == 2) ? 8'h80 : 8'h00}, e, 0);
    end
    e = {8'h2B, 8'h0E, 8'h01, 8'h81, 8'h00, 8'h00, 8'h02};
    add_obj(e, 1);
    add_obj(e, 2);
    run({8'h2B, 8'h0E, 8'h01, 8'h01}, e, 0);
    foreach (e[i])
      if (i < 3)
        run({8'h2B, 8'h0E, 8'h04, (i == 0) ? 8'h03 : (i == 1) ? 8'h07 : 8'h80},
          {8'hAB, 8'h02}, 0);
    $display("identification test done");
  endtask

  task automatic sc_encap_err;
    logic [7:0] r[$];
    run({8'h2B, 8'h0E, 8'h05, 8'h00}, {8'hAB, 8'h03}, 0);
    run({8'h2B, 8'h0E, 8'h00, 8'h00}, {8'hAB, 8'h03}, 0);
    run({8'h2B, 8'h0C}, {8'hAB, 8'h01}, 0);
    run({8'h2B, 8'h0F, 8'h11}, {8'hAB, 8'h01}, 0);
    run({8'h2B, 8'h0D, 8'h01}, {8'hAB, 8'h01}, 0);
    run({8'h2B}, {8'hAB, 8'h03}, 0);
    run({8'h2B, 8'h0E, 8'h01}, {8'hAB, 8'h03}, 0);
    run({8'h03, 8'h00, 8'h00}, {8'h83, 8'h01}, 0);
    for (int n = 253; n <= 254; n++)
    begin
      r = {8'h2B, 8'h0D};
      while (r.size() < n)
        r.push_back(8'h00);
      run(r, {8'hAB, (n > 253) ? 8'h03 : 8'h01}, 0);
    end
    $display("encapsulated error test done");
  endtask

  // Main sequence
  initial
  begin
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_data_i = 8'h00;
    req_last_i = 1'b0;
    rsp_ready_i = 1'b0;
    ptr = 16'h0000;
    cnt = 16'h0000;
    repeat (2) @(negedge mclk_i);
    `CHK(req_ready_o, 1'b1)
    `CHK(rsp_valid_o, 1'b0)
    rst_n_i = 1'b1;
    sc_queue;
    sc_queue_limit;
    sc_ident;
    sc_encap_err;
    tally_and_finish;
  end
endmodule // tb_top
